// ---- verilog/timer_regs.svh ----
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// Register indices, byte address is four times the index
`define PORT2_DIR_IDX      16'hff22
`define TIMER0_CTRL_IDX    16'hff53
`define TIMER1_CTRL_IDX    16'hff57
`define PORT2_LATCH_IDX    16'hff02
`define TIMER0_CMP_IDX     16'hff50
`define TIMER1_CMP_IDX     16'hff51
`define TIMER0_CNT_IDX     16'hff52
`define TIMER1_CNT_IDX     16'hff56

// Field positions and masks
`define RUN_BIT            7
`define T0_SEL_BIT         1
`define T1_SEL_HI          2
`define T1_SEL_LO          1
`define T1_OUT_EN_BIT      0
`define SHARED_PIN_BIT     6
`define T0_CTRL_MASK       8'h82
`define T1_CTRL_MASK       8'h87
`define DIR_FIXED_ONE      8'h80

// Reset values
`define CTRL_RESET         8'h00
`define DIR_RESET          8'hff
`define LATCH_RESET        8'h00
`define CMP_RESET          8'h00

// Prescaler widths (log2 of divide ratio)
`define T0_FAST_BITS       6
`define T0_SLOW_BITS       9
`define T1_FAST_BITS       4
`define T1_SLOW_BITS       8
`define PRESCALE_BITS      9
`endif

// ---- verilog/timer_pkg.sv ----
package timer_pkg;
    // Timer 1 count source codes
    typedef enum logic [1:0] {T1_DIV16, T1_DIV256, T1_RISE, T1_FALL} t1_clk_sel_t;
    typedef logic [7:0] reg_byte_t;
endpackage : timer_pkg

// ---- verilog/timer_chan_if.sv ----
interface timer_chan_if #(parameter int WIDTH = 8);
    logic             tick;
    logic             run;
    logic [WIDTH-1:0] compare;
    logic [WIDTH-1:0] count;
    logic             match;
    modport owner (output tick, output run, output compare, input count, input match);
    modport chan  (input tick, input run, input compare, output count, output match);
endinterface : timer_chan_if

// ---- verilog/edge_sync.sv ----
module edge_sync (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Asynchronous pin
    input  wire logic pin,
    // Single-cycle edge enables
    output logic      rise,
    output logic      fall
);
    logic meta;
    logic stable;
    logic prev;

    // Two-stage synchroniser plus history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta   <= 1'b0;
            stable <= 1'b0;
            prev   <= 1'b0;
        end else begin
            meta   <= pin;
            stable <= meta;
            prev   <= stable;
        end
    end

    assign rise = stable & ~prev;
    assign fall = ~stable & prev;
endmodule : edge_sync

// ---- verilog/timer_channel.sv ----
module timer_channel #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // Control and status
    timer_chan_if.chan ch
);
    logic hit;

    // Compare against current count
    assign hit = (ch.count == ch.compare);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch.count <= {WIDTH{1'b0}};
        end else if (!ch.run) begin
            ch.count <= {WIDTH{1'b0}};
        end else if (ch.tick) begin
            ch.count <= hit ? {WIDTH{1'b0}} : ch.count + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch.match <= 1'b0;
        end else begin
            ch.match <= ch.run & ch.tick & hit;
        end
    end
endmodule : timer_channel

// ---- verilog/dual_8bit_interval_event_timer.sv ----
`include "timer_regs.svh"

module dual_8bit_interval_event_timer
    import timer_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,

    // APB slave
    input  wire logic [17:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,

    // Port 2 pins
    input  wire logic        shared_pin_in,
    output logic      [7:0]  port2_out,
    output logic      [7:0]  port2_oe,

    // Interrupt requests
    output wire logic        timer0_match_irq,
    output wire logic        timer1_match_irq
);

    // Software registers
    reg_byte_t   timer0_control;
    reg_byte_t   timer1_control;
    reg_byte_t   port2_direction;
    reg_byte_t   port2_latch;
    reg_byte_t   timer0_compare;
    reg_byte_t   timer1_compare;

    // Prescaler and decode wires
    logic [`PRESCALE_BITS-1:0] prescale;
    logic [15:0] reg_idx;
    logic        setup;
    logic        wr;
    logic        hit_dir;
    logic        hit_t0c;
    logic        hit_t1c;
    logic        hit_lat;
    logic        hit_t0m;
    logic        hit_t1m;
    logic        hit_t0n;
    logic        hit_t1n;
    logic        mapped;
    reg_byte_t   rd_byte;

    // Count source wires
    t1_clk_sel_t t1_sel;
    logic        t0_tick;
    logic        t1_src;
    logic        ev_rise;
    logic        ev_fall;
    logic        timer_level;
    reg_byte_t   next_port_out;
    reg_byte_t   next_port_oe;

    // Channel links
    timer_chan_if #(.WIDTH(8)) ch0 ();
    timer_chan_if #(.WIDTH(8)) ch1 ();

    // APB phase and address decode
    assign reg_idx = paddr[17:2];
    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pready & pwrite;
    assign hit_dir = (reg_idx == `PORT2_DIR_IDX);
    assign hit_t0c = (reg_idx == `TIMER0_CTRL_IDX);
    assign hit_t1c = (reg_idx == `TIMER1_CTRL_IDX);
    assign hit_lat = (reg_idx == `PORT2_LATCH_IDX);
    assign hit_t0m = (reg_idx == `TIMER0_CMP_IDX);
    assign hit_t1m = (reg_idx == `TIMER1_CMP_IDX);
    assign hit_t0n = (reg_idx == `TIMER0_CNT_IDX);
    assign hit_t1n = (reg_idx == `TIMER1_CNT_IDX);
    assign mapped  = hit_dir | hit_t0c | hit_t1c | hit_lat |
                     hit_t0m | hit_t1m | hit_t0n | hit_t1n;

    assign rd_byte = hit_dir ? port2_direction :
                     hit_t0c ? timer0_control  :
                     hit_t1c ? timer1_control  :
                     hit_lat ? port2_latch     :
                     hit_t0m ? timer0_compare  :
                     hit_t1m ? timer1_compare  :
                     hit_t0n ? ch0.count       :
                     hit_t1n ? ch1.count       : 8'h00;

    // Answer in the cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            prdata  <= (setup & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer0_control <= `CTRL_RESET;
            timer1_control <= `CTRL_RESET;
        end else begin
            if (wr & hit_t0c) begin
                timer0_control <= pwdata[7:0] & `T0_CTRL_MASK;
            end
            if (wr & hit_t1c) begin
                timer1_control <= pwdata[7:0] & `T1_CTRL_MASK;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port2_direction <= `DIR_RESET;
            port2_latch     <= `LATCH_RESET;
        end else begin
            if (wr & hit_dir) begin
                port2_direction <= pwdata[7:0] | `DIR_FIXED_ONE;
            end
            if (wr & hit_lat) begin
                port2_latch <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer0_compare <= `CMP_RESET;
            timer1_compare <= `CMP_RESET;
        end else begin
            if (wr & hit_t0m) begin
                timer0_compare <= pwdata[7:0];
            end
            if (wr & hit_t1m) begin
                timer1_compare <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 1'b1;
        end
    end

    // Pin event synchroniser
    edge_sync u_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (shared_pin_in),
        .rise    (ev_rise),
        .fall    (ev_fall)
    );

    assign t0_tick = timer0_control[`T0_SEL_BIT] ? &prescale[`T0_SLOW_BITS-1:0]
                                                 : &prescale[`T0_FAST_BITS-1:0];

    assign t1_sel = t1_clk_sel_t'(timer1_control[`T1_SEL_HI:`T1_SEL_LO]);
    assign t1_src = (t1_sel == T1_DIV16)  ? &prescale[`T1_FAST_BITS-1:0] :
                    (t1_sel == T1_DIV256) ? &prescale[`T1_SLOW_BITS-1:0] :
                    (t1_sel == T1_RISE)   ? ev_rise : ev_fall;

    assign ch0.run     = timer0_control[`RUN_BIT];
    assign ch0.tick    = ch0.run & t0_tick;
    assign ch0.compare = timer0_compare;

    assign ch1.run     = timer1_control[`RUN_BIT];
    assign ch1.tick    = ch1.run & t1_src;
    assign ch1.compare = timer1_compare;

    // Counter and match channels
    timer_channel #(.WIDTH(8)) u_timer0 (
        .pclk    (pclk),
        .presetn (presetn),
        .ch      (ch0.chan)
    );

    timer_channel #(.WIDTH(8)) u_timer1 (
        .pclk    (pclk),
        .presetn (presetn),
        .ch      (ch1.chan)
    );

    // Match requests leave from channel flops
    assign timer0_match_irq = ch0.match;
    assign timer1_match_irq = ch1.match;

    assign timer_level   = 1'b0;       // Timer output held low, never toggled
    assign next_port_out = timer1_control[`T1_OUT_EN_BIT]
                         ? {port2_latch[7], timer_level, port2_latch[5:0]}
                         : port2_latch;
    assign next_port_oe  = ~port2_direction;

    // Registered pin drivers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port2_out <= `LATCH_RESET;
            port2_oe  <= ~`DIR_RESET;
        end else begin
            port2_out <= next_port_out;
            port2_oe  <= next_port_oe;
        end
    end

    // First cycle after reset release
    logic after_reset;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            after_reset <= 1'b1;
        end else begin
            after_reset <= 1'b0;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Match steps of each channel
    sequence t0_match_step;
        ch0.tick && (ch0.count == ch0.compare);
    endsequence

    sequence t1_match_step;
        ch1.tick && (ch1.count == ch1.compare);
    endsequence

    sequence apb_setup;
        psel && !penable;
    endsequence

    sequence t1c_write_step;
        psel && penable && pready && pwrite && hit_t1c;
    endsequence

    t0_stop_clear_a: assert property (!timer0_control[7] |=> ch0.count == 8'h00)
        else $error("timer 0 counter not cleared while stopped");

    t0_tick_rate_a: assert property (ch0.tick |->
        (timer0_control[1] ? (prescale == 9'h1ff) : (prescale[5:0] == 6'h3f)))
        else $error("timer 0 tick at wrong divider phase");

    t1_stop_clear_a: assert property (!timer1_control[7] |=> ch1.count == 8'h00)
        else $error("timer 1 counter not cleared while stopped");

    t1_div_rate_a: assert property (ch1.tick && !timer1_control[2] |->
        (timer1_control[1] ? (prescale[7:0] == 8'hff) : (prescale[3:0] == 4'hf)))
        else $error("timer 1 tick at wrong divider phase");

    pin_mux_a: assert property (timer1_control[0] && !port2_direction[6]
        |=> port2_oe[6] && !port2_out[6])
        else $error("shared pin not driven by timer output");

    reset_value_a: assert property (after_reset |->
        timer0_control == 8'h00 && timer1_control == 8'h00 && port2_direction == 8'hff)
        else $error("control registers wrong after reset");

    dir_fixed_a: assert property (port2_direction[7] && !port2_oe[7])
        else $error("port 2 bit 7 direction not fixed to input");

    t0_match_a: assert property (t0_match_step |=> ch0.count == 8'h00 && timer0_match_irq)
        else $error("timer 0 match did not clear and request");

    t1_match_a: assert property (t1_match_step |=> ch1.count == 8'h00 && timer1_match_irq)
        else $error("timer 1 match did not clear and request");

    t0_step_a: assert property (ch0.tick && ch0.count != ch0.compare
        |=> ch0.count == $past(ch0.count) + 8'h01 && !timer0_match_irq)
        else $error("timer 0 did not step by one");

    t1_event_a: assert property (timer1_control[7] && timer1_control[2:1] == 2'b10
        |-> ch1.tick == ev_rise)
        else $error("timer 1 event tick differs from pin rise");

    cnt_read_a: assert property ((apb_setup and (!pwrite && reg_idx == `TIMER0_CNT_IDX))
        |=> pready && prdata == {24'h00_0000, $past(ch0.count)})
        else $error("timer 0 count readback wrong");

    edge_pulse_a: assert property (ev_rise |=> !ev_rise ##1 !ev_rise)
        else $error("pin edge enable longer than one cycle");

    tick_pulse_a: assert property (ch1.tick && !timer1_control[2] |=> !ch1.tick [*8])
        else $error("prescaled tick repeated too soon");

    t1_cnt_read_a: assert property ((apb_setup and (!pwrite && reg_idx == `TIMER1_CNT_IDX))
        |=> pready && prdata == {24'h00_0000, $past(ch1.count)})
        else $error("timer 1 count readback wrong");

    // byte write to timer 1 control
    t1_ctrl_write_a: assert property (t1c_write_step |=>
        timer1_control == {$past(pwdata[7]), 4'h0, $past(pwdata[2:0])})
        else $error("timer 1 control write not taken");

    t1_stop_irq_a: assert property (!timer1_control[7] |=> !timer1_match_irq)
        else $error("stopped timer 1 raised a match request");

    t0_stop_irq_a: assert property (!timer0_control[7] |=> !timer0_match_irq)
        else $error("stopped timer 0 raised a match request");

    dir_input_a: assert property (port2_direction[6] |=> !port2_oe[6])
        else $error("shared pin driven while set to input");

    // Unmapped index answered with error
    bus_error_a: assert property ((apb_setup and !mapped) |=> pready && pslverr)
        else $error("unmapped access not refused");

endmodule : dual_8bit_interval_event_timer

// ---- verification/pulse_source.sv ----
module pulse_source (
    // Pin towards the block
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle low between bursts, never left floating
    initial begin
        pin = 1'b0;
    end

    // Burst of high pulses at any phase to pclk
    // pin driven always; it reaches the block only while port2_oe[6] is low
    task automatic burst(input int n, input int width);
        repeat (n) begin
            #(width) pin = 1'b1;
            #(width) pin = 1'b0;
        end
    endtask : burst
endmodule : pulse_source

// ---- verification/test_dual_8bit_interval_event_timer.sv ----
`include "timer_regs.svh"

module test_dual_8bit_interval_event_timer
    import timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Stimulus and observed outputs
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic [17:0] paddr   = 18'h0_0000;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  port2_out;
    logic [7:0]  port2_oe;
    logic        src_pin;
    wire logic   shared_pin;
    wire logic   irq0;
    wire logic   irq1;
    int          n_fail  = 0;
    int          checked = 0;
    int          cycles  = 0;
    int          n_irq1  = 0;

    // Interval cases: timer 0 fast/slow, timer 1 fast/slow
    logic [15:0] ctl[4] = '{`TIMER0_CTRL_IDX, `TIMER0_CTRL_IDX, `TIMER1_CTRL_IDX, `TIMER1_CTRL_IDX};
    logic [15:0] cmp[4] = '{`TIMER0_CMP_IDX, `TIMER0_CMP_IDX, `TIMER1_CMP_IDX, `TIMER1_CMP_IDX};
    logic [15:0] cnt[4] = '{`TIMER0_CNT_IDX, `TIMER0_CNT_IDX, `TIMER1_CNT_IDX, `TIMER1_CNT_IDX};
    reg_byte_t   sel[4] = '{8'h00, 8'h02, 8'h00, 8'h02};
    reg_byte_t   nmax[4] = '{8'h1f, 8'h03, 8'hff, 8'h07};
    int          dv[4]  = '{64, 512, 16, 256};

    // Pin level from block driver or external source
    assign shared_pin = port2_oe[6] ? port2_out[6] : src_pin;

    dual_8bit_interval_event_timer dut_u (
        .pclk             (pclk),
        .presetn          (presetn),
        .paddr            (paddr),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .shared_pin_in    (shared_pin),
        .port2_out        (port2_out),
        .port2_oe         (port2_oe),
        .timer0_match_irq (irq0),
        .timer1_match_irq (irq1)
    );

    pulse_source src_u (
        .pin (src_pin)
    );

    // Clock
    initial begin
        forever #5 pclk = ~pclk;
    end

    // Hang guard and timer 1 request count
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_fail++;
            finish_test();
        end
    end
    always @(negedge pclk) begin
        if (irq1 === 1'b1) n_irq1++;
    end

    function automatic logic [15:0] exp_period(input reg_byte_t n, input int d);
        return 16'((int'(n) + 1) * d);
    endfunction : exp_period

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // One APB transfer, held until pready
    task automatic apb(input logic [15:0] idx, input logic w, input reg_byte_t d,
                       output reg_byte_t r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= {idx, 2'b00};
        pwrite <= w;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Request stands until pready is seen high at a rising edge
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [15:0] idx, input reg_byte_t d);
        reg_byte_t r;
        logic      e;
        apb(idx, 1'b1, d, r, e);
    endtask : wr

    task automatic rd(input logic [15:0] idx, input reg_byte_t exp);
        reg_byte_t r;
        logic      e;
        apb(idx, 1'b0, 8'h00, r, e);
        check(16'(r), 16'(exp), "register read");
        check(16'(e), 16'h0000, "register read error");
    endtask : rd

    // Cycles from one match request to the next
    task automatic gap(input int w, output int p);
        int c;
        c = 0;
        do begin
            @(negedge pclk);
            c++;
        end while ((w ? irq1 : irq0) !== 1'b1 && c < 9000);
        p = 0;
        do begin
            @(negedge pclk);
            p++;
        end while ((w ? irq1 : irq0) !== 1'b1 && p < 9000);
    endtask : gap

    task automatic finish_test();
        if (n_fail == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    // Main sequence
    initial begin
        reg_byte_t r;
        logic      e;
        reg_byte_t v;
        int        p;
        void'($urandom(64));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(`PORT2_DIR_IDX, 8'hff);
        rd(`TIMER0_CTRL_IDX, 8'h00);
        rd(`TIMER1_CTRL_IDX, 8'h00);
        rd(`TIMER0_CNT_IDX, 8'h00);
        rd(`TIMER1_CNT_IDX, 8'h00);
        check(16'(port2_oe), 16'h0000, "enables after reset");
        apb(16'h0004, 1'b0, 8'h00, r, e);
        check(16'(e), 16'h0001, "unmapped error");
        // Random register contents and masks
        repeat (4) begin
            v = reg_byte_t'($urandom);
            wr(`PORT2_DIR_IDX, v);
            rd(`PORT2_DIR_IDX, v | 8'h80);
            check({8'h00, port2_oe}, {8'h00, ~(v | 8'h80)}, "pin enables");
            v = reg_byte_t'($urandom) & 8'h7f;
            wr(`TIMER0_CTRL_IDX, v);
            rd(`TIMER0_CTRL_IDX, v & 8'h02);
            wr(`TIMER1_CTRL_IDX, v);
            rd(`TIMER1_CTRL_IDX, v & 8'h07);
        end
        wr(`PORT2_DIR_IDX, 8'hff);
        // Interval periods, boundary then random compare, zero compare for timer 1 fast
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 2; j++) begin
                v = (j == 0) ? nmax[i] : (i == 2) ? 8'h00 : reg_byte_t'($urandom) & nmax[i];
                wr(ctl[i], sel[i]);
                wr(cmp[i], v);
                rd(cmp[i], v);
                wr(ctl[i], sel[i] | 8'h80);
                gap(i / 2, p);
                check(16'(p), exp_period(v, dv[i]), "interval");
                wr(ctl[i], sel[i]);
                rd(cnt[i], 8'h00);
            end
        end
        // Pin edge counting, rising then falling
        for (int k = 0; k < 2; k++) begin
            wr(`TIMER1_CTRL_IDX, k ? 8'h06 : 8'h04);
            wr(`TIMER1_CMP_IDX, 8'hff);
            wr(`TIMER1_CTRL_IDX, k ? 8'h86 : 8'h84);
            v = (reg_byte_t'($urandom) & 8'h07) | 8'h01;
            src_u.burst(int'(v), int'(30 + $urandom % 150));
            repeat (5) @(posedge pclk);
            rd(`TIMER1_CNT_IDX, v);
            wr(`TIMER1_CTRL_IDX, k ? 8'h06 : 8'h04);
            wr(`TIMER1_CMP_IDX, 8'h02);
            wr(`TIMER1_CTRL_IDX, k ? 8'h86 : 8'h84);
            p = n_irq1;
            src_u.burst(3, 40);
            repeat (5) @(posedge pclk);
            check(16'(n_irq1 - p), 16'h0001, "event match");
            rd(`TIMER1_CNT_IDX, 8'h00);
        end
        // Timer output onto the shared pin
        wr(`TIMER1_CTRL_IDX, 8'h00);
        wr(`PORT2_LATCH_IDX, 8'h40);
        wr(`PORT2_DIR_IDX, 8'hbf);
        repeat (2) @(negedge pclk);
        check(16'(port2_out), 16'h0040, "port mode level");
        wr(`PORT2_LATCH_IDX, 8'h00);
        wr(`TIMER1_CTRL_IDX, 8'h01);
        repeat (2) @(negedge pclk);
        check(16'({port2_oe[6], port2_out[6]}), 16'h0002, "timer output");
        wr(`TIMER1_CTRL_IDX, 8'h00);
        wr(`PORT2_DIR_IDX, 8'hff);
        finish_test();
    end
endmodule : test_dual_8bit_interval_event_timer
